/* hdl/emb_pkg.sv */
package emb_pkg;
   // ==========================================
   // bus widths
   localparam int EMB_DATA_W       = 8;
   localparam int EMB_ADDR_W_SMALL = 11;
   localparam int EMB_ADDR_W_LARGE = 22;
   // ==========================================
   // reset vector
   localparam logic [21:0] EMB_VEC_LO_ADDR = 22'h000000;
   localparam logic [21:0] EMB_VEC_HI_ADDR = 22'h000001;
   // ==========================================
   // cycle phase lengths in ref_clk cycles
   localparam int EMB_ADDR_CYC = 1;
   localparam int EMB_DATA_CYC = 2;
   // ==========================================
   // pull-up enable after reset
   localparam int          EMB_PORT_W     = 8;
   localparam logic [7:0]  EMB_PULLUP_RST = 8'hff;
   // ==========================================
   // cycle states, one-hot
   typedef enum logic [4:0] {
      EMB_IDLE  = 5'h01,
      EMB_ADDR  = 5'h02,
      EMB_LATCH = 5'h04,
      EMB_DATA  = 5'h08,
      EMB_DONE  = 5'h10
   } emb_state_t;
endpackage

/* hdl/emb_phase_if.sv */
`timescale 1ns/10ps
interface emb_phase_if;
   logic load;
   logic expired;
   logic [3:0] count;
   modport ctl (output load, output count, input expired);
   modport tmr (input load, input count, output expired);
endinterface

/* hdl/emb_phase_timer.sv */
`timescale 1ns/10ps
module emb_phase_timer (
   input  wire logic  ref_clk,
   input  wire logic  srst,
   emb_phase_if.tmr   ph
);
   import emb_pkg::*;
   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;
   logic       exp_r;
   logic       exp_nxt;
   always_comb begin
      cnt_nxt = cnt_r;
      exp_nxt = 1'b0;
      if (ph.load) begin
         cnt_nxt = ph.count;
      end else if (cnt_r != 4'h0) begin
         cnt_nxt = cnt_r - 4'h1;
         exp_nxt = (cnt_r == 4'h1);
      end
   end
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cnt_r <= 4'h0;
         exp_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         exp_r <= exp_nxt;
      end
   end
   assign ph.expired = exp_r;
endmodule

/* hdl/emb_strobes.sv */
// Summary of operation
// - the address strobe pulses low once at the start of every memory cycle.
// - address, direction and write data are stable before the address strobe rises.
// - on writes, output data is valid no later than the data strobe falling edge.
// - cycles to on-chip memory keep the data strobe high throughout.
// - the direction line is low only for external writes, high otherwise.
// - after reset, the start vector is fetched from bytes 00h and 01h, then execution starts there.
// - strobes and direction line can be released to high impedance.
// - the watchdog strap is sampled: high selects software, low selects hardware watchdog.
// - the address bus is 11 lines on the small variant or 22 lines on the large one.
// - all port pins have weak pull-ups enabled after reset.
`timescale 1ns/10ps
module emb_strobes #(
   parameter bit LARGE_PKG = 1'b1
) (
   input  wire logic                              ref_clk,
   input  wire logic                              srst,
   input  wire logic                              req_valid,
   input  wire logic                              req_write,
   input  wire logic                              req_internal,
   input  wire logic [emb_pkg::EMB_ADDR_W_LARGE-1:0] req_addr,
   input  wire logic [emb_pkg::EMB_DATA_W-1:0]    req_wdata,
   input  wire logic                              bus_release,
   input  wire logic                              watchdog_select_strap,
   input  wire logic [emb_pkg::EMB_DATA_W-1:0]    port_zero_bus_in,
   output logic                                   req_ready,
   output logic                                   rsp_valid,
   output logic [emb_pkg::EMB_DATA_W-1:0]         rsp_rdata,
   output logic                                   boot_busy,
   output logic [emb_pkg::EMB_ADDR_W_LARGE-1:0]   start_addr,
   output logic                                   wdog_sw_mode,
   output logic                                   addr_latch_strobe_n,
   output logic                                   addr_latch_strobe_oe,
   output logic                                   xfer_timing_strobe_n,
   output logic                                   xfer_timing_strobe_oe,
   output logic                                   rw_dir,
   output logic                                   rw_dir_oe,
   output logic [emb_pkg::EMB_ADDR_W_LARGE-1:0]   ext_addr,
   output logic [emb_pkg::EMB_DATA_W-1:0]         port_zero_bus_out,
   output logic                                   port_zero_bus_oe,
   output logic [emb_pkg::EMB_PORT_W-1:0]         pullup_en
);
   import emb_pkg::*;

   localparam int AW = LARGE_PKG ? EMB_ADDR_W_LARGE : EMB_ADDR_W_SMALL;
   localparam logic [AW-1:0] AMASK = AW'({AW{1'b1}});

   if (EMB_DATA_CYC < 1 || EMB_DATA_CYC > 15 || EMB_ADDR_CYC != 1) begin : g_bad_phase
      $error("emb_strobes: phase lengths out of range");
   end

   emb_phase_if ph ();
   emb_phase_timer u_timer (
      .ref_clk (ref_clk),
      .srst    (srst),
      .ph      (ph)
   );

   // ==========================================
   // cycle sequencer
   emb_state_t             st_r, st_nxt;
   logic                   boot_r, boot_nxt;
   logic                   vec_hi_r, vec_hi_nxt;
   logic                   strap_done_r, strap_done_nxt;
   logic                   wr_r, wr_nxt;
   logic                   int_r, int_nxt;
   logic [21:0]            addr_r, addr_nxt;
   logic [7:0]             wd_r, wd_nxt;
   logic [7:0]             rd_r, rd_nxt;
   logic                   rv_r, rv_nxt;
   logic                   rdy_r, rdy_nxt;
   logic [21:0]            start_r, start_nxt;
   logic                   sw_r, sw_nxt;
   logic                   as_n_r, as_n_nxt;
   logic                   ds_n_r, ds_n_nxt;
   logic                   rw_r, rw_nxt;
   logic                   d_oe_r, d_oe_nxt;
   logic                   oe_r, oe_nxt;

   function automatic logic [21:0] mask_addr(input logic [21:0] a);
      mask_addr = a & 22'(AMASK);
   endfunction

   always_comb begin
      st_nxt         = st_r;
      boot_nxt       = boot_r;
      vec_hi_nxt     = vec_hi_r;
      strap_done_nxt = 1'b1;
      wr_nxt         = wr_r;
      int_nxt        = int_r;
      addr_nxt       = addr_r;
      wd_nxt         = wd_r;
      rd_nxt         = rd_r;
      rv_nxt         = 1'b0;
      rdy_nxt        = 1'b0;
      start_nxt      = start_r;
      sw_nxt         = strap_done_r ? sw_r : watchdog_select_strap;
      as_n_nxt       = 1'b1;
      ds_n_nxt       = 1'b1;
      rw_nxt         = 1'b1;
      d_oe_nxt       = 1'b0;
      oe_nxt         = !bus_release;
      ph.load        = 1'b0;
      ph.count       = 4'h0;
      case (st_r)
         EMB_IDLE: begin
            if (boot_r) begin
               wr_nxt   = 1'b0;
               int_nxt  = 1'b0;
               addr_nxt = vec_hi_r ? EMB_VEC_HI_ADDR : EMB_VEC_LO_ADDR;
               st_nxt   = EMB_ADDR;
            end else if (req_valid && !rdy_r) begin
               rdy_nxt  = 1'b1;
               wr_nxt   = req_write;
               int_nxt  = req_internal;
               addr_nxt = mask_addr(req_addr);
               wd_nxt   = req_wdata;
               st_nxt   = EMB_ADDR;
            end
         end
         EMB_ADDR: begin
            as_n_nxt = 1'b0;
            rw_nxt   = !(wr_r && !int_r);
            d_oe_nxt = wr_r && !int_r;
            st_nxt   = EMB_LATCH;
         end
         EMB_LATCH: begin
            rw_nxt   = !(wr_r && !int_r);
            d_oe_nxt = wr_r && !int_r;
            ds_n_nxt = int_r;
            ph.load  = 1'b1;
            ph.count = 4'(EMB_DATA_CYC);
            st_nxt   = EMB_DATA;
         end
         EMB_DATA: begin
            rw_nxt   = !(wr_r && !int_r);
            d_oe_nxt = wr_r && !int_r;
            ds_n_nxt = int_r;
            if (ph.expired) begin
               ds_n_nxt = 1'b1;
               rd_nxt   = port_zero_bus_in;
               st_nxt   = EMB_DONE;
            end
         end
         EMB_DONE: begin
            st_nxt = EMB_IDLE;
            if (boot_r) begin
               if (!vec_hi_r) begin
                  start_nxt[15:8] = rd_r;
                  vec_hi_nxt      = 1'b1;
               end else begin
                  start_nxt[7:0] = rd_r;
                  boot_nxt       = 1'b0;
               end
            end else begin
               rv_nxt = !wr_r;
            end
         end
         default: st_nxt = EMB_IDLE;
      endcase
      // data driver follows the release request like the strobes
      d_oe_nxt = d_oe_nxt && !bus_release;
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         st_r         <= EMB_IDLE;
         boot_r       <= 1'b1;
         vec_hi_r     <= 1'b0;
         strap_done_r <= 1'b0;
         wr_r         <= 1'b0;
         int_r        <= 1'b0;
         addr_r       <= 22'h000000;
         wd_r         <= 8'h00;
         rd_r         <= 8'h00;
         rv_r         <= 1'b0;
         rdy_r        <= 1'b0;
         start_r      <= 22'h000000;
         sw_r         <= 1'b0;
         as_n_r       <= 1'b1;
         ds_n_r       <= 1'b1;
         rw_r         <= 1'b1;
         d_oe_r       <= 1'b0;
         oe_r         <= 1'b1;
         pullup_en    <= EMB_PULLUP_RST;
      end else begin
         st_r         <= st_nxt;
         boot_r       <= boot_nxt;
         vec_hi_r     <= vec_hi_nxt;
         strap_done_r <= strap_done_nxt;
         wr_r         <= wr_nxt;
         int_r        <= int_nxt;
         addr_r       <= addr_nxt;
         wd_r         <= wd_nxt;
         rd_r         <= rd_nxt;
         rv_r         <= rv_nxt;
         rdy_r        <= rdy_nxt;
         start_r      <= start_nxt;
         sw_r         <= sw_nxt;
         as_n_r       <= as_n_nxt;
         ds_n_r       <= ds_n_nxt;
         rw_r         <= rw_nxt;
         d_oe_r       <= d_oe_nxt;
         oe_r         <= oe_nxt;
         pullup_en    <= pullup_en;
      end
   end

   // ==========================================
   // pin outputs
   always_comb begin
      req_ready             = rdy_r;
      rsp_valid             = rv_r;
      rsp_rdata             = rd_r;
      boot_busy             = boot_r;
      start_addr            = start_r;
      wdog_sw_mode          = sw_r;
      addr_latch_strobe_n   = as_n_r;
      xfer_timing_strobe_n  = ds_n_r;
      rw_dir                = rw_r;
      addr_latch_strobe_oe  = oe_r;
      xfer_timing_strobe_oe = oe_r;
      rw_dir_oe             = oe_r;
      ext_addr              = addr_r;
      port_zero_bus_out     = wd_r;
      port_zero_bus_oe      = d_oe_r;
   end
endmodule

/* test/emb_mem_model.sv */
`timescale 1ns/10ps
module emb_mem_model (
   input  wire logic        ref_clk,
   input  wire logic        ds_n,
   input  wire logic        rw,
   input  wire logic [21:0] addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        d_oe,
   output logic      [7:0]  rdata
);
   logic [7:0] mem [256];
   logic [7:0] last_r;
   initial begin
      mem[0] = 8'h12;
      mem[1] = 8'h34;
      last_r = 8'h00;
   end
   // bus floats when not read: show inverse of last value
   assign rdata = (!ds_n && rw) ? mem[addr[7:0]] : ~last_r;
   always @(posedge ref_clk) begin
      last_r <= rdata;
      if (!ds_n && !rw && d_oe) mem[addr[7:0]] <= wdata;
   end
endmodule

/* test/emb_strobes_props.sv */
`timescale 1ns/10ps
module emb_strobes_props (
   input wire logic        ref_clk,
   input wire logic        srst,
   input wire logic        req_write,
   input wire logic        req_internal,
   input wire logic        bus_release,
   input wire logic        req_ready,
   input wire logic        rsp_valid,
   input wire logic        addr_latch_strobe_n,
   input wire logic        addr_latch_strobe_oe,
   input wire logic        xfer_timing_strobe_n,
   input wire logic        xfer_timing_strobe_oe,
   input wire logic        rw_dir,
   input wire logic        rw_dir_oe,
   input wire logic [21:0] ext_addr,
   input wire logic [7:0]  port_zero_bus_out,
   input wire logic        port_zero_bus_oe,
   input wire logic [7:0]  pullup_en
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   property p_as; $fell(addr_latch_strobe_n) |=> addr_latch_strobe_n; endproperty
   a_as: assert property (p_as) else $error("address strobe not one cycle");
   property p_vld; $rose(addr_latch_strobe_n) |-> $stable(ext_addr) && $stable(rw_dir); endproperty
   a_vld: assert property (p_vld) else $error("address moved at strobe rise");
   property p_wd; $fell(xfer_timing_strobe_n) && !rw_dir && rw_dir_oe |->
      port_zero_bus_oe && $stable(port_zero_bus_out); endproperty
   a_wd: assert property (p_wd) else $error("write data late");
   property p_int; req_ready && $past(req_internal) |-> xfer_timing_strobe_n [*6]; endproperty
   a_int: assert property (p_int) else $error("data strobe on internal cycle");
   property p_rw; req_ready && !($past(req_write) && !$past(req_internal)) |-> rw_dir [*6];
   endproperty
   a_rw: assert property (p_rw) else $error("direction low on non-write");
   property p_rel; bus_release |=> !addr_latch_strobe_oe && !xfer_timing_strobe_oe && !rw_dir_oe;
   endproperty
   a_rel: assert property (p_rel) else $error("strobes not released");
   property p_pu; $fell(srst) |-> pullup_en == 8'hff; endproperty
   a_pu: assert property (p_pu) else $error("pull-ups off after reset");
   property p_ds; $fell(xfer_timing_strobe_n) |-> $rose(addr_latch_strobe_n) ##1
      !xfer_timing_strobe_n [*2] ##1 xfer_timing_strobe_n [*2]; endproperty
   a_ds: assert property (p_ds) else $error("data strobe order or length wrong");
   property p_rsp; req_ready && !$past(req_write) && !$past(req_internal) |-> ##6 rsp_valid;
   endproperty
   a_rsp: assert property (p_rsp) else $error("read answer late");
endmodule

/* test/emb_strobes_tb.sv */
`timescale 1ns/10ps
module emb_strobes_tb;
   import emb_pkg::*;
   logic ref_clk = 0, srst = 1, req_valid = 0, req_write = 0, req_internal = 0;
   logic bus_release = 0, strap = 1;
   logic [21:0] req_addr = 22'h0, start_addr, ext_addr;
   logic [7:0]  req_wdata = 8'h0, p0_in, p0_out, rsp_rdata, pullup_en;
   logic req_ready, rsp_valid, boot_busy, wdog_sw_mode, as_n, as_oe, ds_n, ds_oe, rw, rw_oe, d_oe;
   int miscompares = 0, checks = 0;
   emb_strobes #(.LARGE_PKG(1'b1)) u_dut (.ref_clk, .srst, .req_valid, .req_write, .req_internal,
      .req_addr, .req_wdata, .bus_release, .watchdog_select_strap(strap), .port_zero_bus_in(p0_in),
      .req_ready, .rsp_valid, .rsp_rdata, .boot_busy, .start_addr, .wdog_sw_mode,
      .addr_latch_strobe_n(as_n), .addr_latch_strobe_oe(as_oe), .xfer_timing_strobe_n(ds_n),
      .xfer_timing_strobe_oe(ds_oe), .rw_dir(rw), .rw_dir_oe(rw_oe), .ext_addr,
      .port_zero_bus_out(p0_out), .port_zero_bus_oe(d_oe), .pullup_en);
   emb_mem_model u_mem (.ref_clk, .ds_n, .rw, .addr(ext_addr), .wdata(p0_out), .d_oe,
      .rdata(p0_in));
   initial forever #50 ref_clk = ~ref_clk;
   task automatic chk(string what, logic [21:0] exp, logic [21:0] got);
      checks++;
      if (!(got === exp)) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic do_reset(logic s);
      strap = s;
      srst = 1;
      repeat (5) @(negedge ref_clk);
      srst = 0;
      @(negedge ref_clk);
      chk("pullup", 22'h0000ff, {14'h0, pullup_en});
      for (int i = 0; i < 60 && boot_busy !== 1'b0; i++) @(negedge ref_clk);
      chk("boot_busy", 22'h0, {21'h0, boot_busy});
   endtask
   task automatic do_req(logic w, logic in, logic [21:0] a, logic [7:0] d);
      int n = 0, as_lo = 0, ds_lo = 0, rw_lo = 0, wr_ok = 0, rv = 0;
      req_write = w;
      req_internal = in;
      req_addr = a;
      req_wdata = d;
      req_valid = 1;
      while (req_ready !== 1'b1 && n < 20) begin
         @(negedge ref_clk);
         n++;
      end
      req_valid = 0;
      chk("req_ready", 22'h1, {21'h0, req_ready});
      chk("ext_addr", a, ext_addr);
      repeat (8) begin
         @(negedge ref_clk);
         if (as_n === 1'b0) as_lo++;
         if (ds_n === 1'b0) ds_lo++;
         if (rw === 1'b0) rw_lo++;
         if (ds_n === 1'b0 && rw === 1'b0 && d_oe === 1'b1 && p0_out === d) wr_ok++;
         if (rsp_valid === 1'b1) rv++;
      end
      chk("as_low_cycles", 22'h1, as_lo[21:0]);
      chk("ds_low_cycles", in ? 22'h0 : 22'(EMB_DATA_CYC + 1), ds_lo[21:0]);
      chk("rw_low", {21'h0, w && !in}, {21'h0, rw_lo != 0});
      chk("write_data", (w && !in) ? 22'(EMB_DATA_CYC + 1) : 22'h0, wr_ok[21:0]);
      chk("rsp_valid", {21'h0, !w}, rv[21:0]);
   endtask
   task automatic t_boot();
      do_reset(1'b1);
      chk("start_addr", 22'h001234, start_addr);
      chk("wdog_sw", 22'h1, {21'h0, wdog_sw_mode});
      $display("test boot done");
   endtask
   task automatic t_rw();
      do_req(1'b1, 1'b0, 22'h3abc5e, 8'h5a);
      do_req(1'b0, 1'b0, 22'h3abc5e, 8'h00);
      chk("rdata", 22'h00005a, {14'h0, rsp_rdata});
      do_req(1'b0, 1'b1, 22'h000010, 8'h00);
      do_req(1'b1, 1'b1, 22'h000020, 8'h77);
      $display("test write read done");
   endtask
   task automatic t_release();
      bus_release = 1;
      repeat (2) @(negedge ref_clk);
      chk("oe", 22'h0, {18'h0, as_oe, ds_oe, rw_oe, d_oe});
      bus_release = 0;
      repeat (2) @(negedge ref_clk);
      chk("oe_back", 22'h7, {19'h0, as_oe, ds_oe, rw_oe});
      do_reset(1'b0);
      chk("wdog_hw", 22'h0, {21'h0, wdog_sw_mode});
      $display("test release strap done");
   endtask
   task automatic final_report();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #(5000 * 100);
      miscompares++;
      final_report();
   end
   initial begin
      t_boot();
      t_rw();
      t_release();
      final_report();
   end
endmodule
bind emb_strobes emb_strobes_props u_props (.ref_clk, .srst, .req_write, .req_internal,
   .bus_release, .req_ready, .rsp_valid, .addr_latch_strobe_n, .addr_latch_strobe_oe,
   .xfer_timing_strobe_n, .xfer_timing_strobe_oe, .rw_dir, .rw_dir_oe, .ext_addr,
   .port_zero_bus_out, .port_zero_bus_oe, .pullup_en);
